// ===== verilog/insn_move_pkg.sv
// constants, types and opcodes shared by the data-move and timer-load executor
package insn_move_pkg;

    // ------------------------------------------------------------
    // widths and field positions of the 16-bit instruction word
    // ------------------------------------------------------------
    localparam int NIB_W      = 4;
    localparam int RAM_AW     = 7;
    localparam int RAM_DEPTH  = 128;
    localparam int PAGE_USED  = 3;
    localparam int IMM_MSB    = 7;
    localparam int R_MSB      = 6;
    localparam int W_MSB      = 10;
    localparam int W_LSB      = 7;
    localparam int TIMERS     = 2;

    // ------------------------------------------------------------
    // opcode prefixes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_TM0_IMM = 8'h10;
    localparam logic [7:0] OPC_TM1_IMM = 8'h11;
    localparam logic [8:0] OPC_FIRST_TIMER_PRESET_LOW    = 9'h028;
    localparam logic [8:0] OPC_FIRST_TIMER_PRESET_HIGH    = 9'h029;
    localparam logic [8:0] OPC_SECOND_TIMER_PRESET_LOW    = 9'h02a;
    localparam logic [8:0] OPC_SECOND_TIMER_PRESET_HIGH    = 9'h02b;
    localparam logic [4:0] OPC_MOV_WR  = 5'h1d;
    localparam logic [4:0] OPC_LD_IND  = 5'h19;
    localparam logic [4:0] OPC_ST_IND  = 5'h1b;
    localparam logic [7:0] OPC_PAGE    = 8'h5d;
    localparam logic [8:0] OPC_CF_COPY = 9'h0b2;

    // ------------------------------------------------------------
    // reset values and timing in core clocks
    // ------------------------------------------------------------
    localparam logic [3:0] NIB_RST      = 4'h0;
    localparam logic [7:0] TMR_RST      = 8'h00;
    localparam int         MCYCLE_CLKS  = 2;
    localparam int         IND_CLKS     = 2 * MCYCLE_CLKS;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_STEP1 = 2'b01,
        S_STEP2 = 2'b10,
        S_STEP3 = 2'b11
    } state_type;

    typedef enum logic [3:0] {
        OP_NONE    = 4'b0000,
        OP_TM0_IMM = 4'b0001,
        OP_TM1_IMM = 4'b0010,
        OP_FIRST_TIMER_PRESET_LOW    = 4'b0011,
        OP_FIRST_TIMER_PRESET_HIGH    = 4'b0100,
        OP_SECOND_TIMER_PRESET_LOW    = 4'b0101,
        OP_SECOND_TIMER_PRESET_HIGH    = 4'b0110,
        OP_MOV_WR  = 4'b0111,
        OP_LD_IND  = 4'b1000,
        OP_ST_IND  = 4'b1001,
        OP_PAGE    = 4'b1010,
        OP_CF_COPY = 4'b1011
    } op_type;

    typedef struct packed {
        logic              we;
        logic [RAM_AW-1:0] addr;
        logic [NIB_W-1:0]  data;
    } ram_wr_type;

    typedef struct packed {
        logic             load;
        logic [7:0]       value;
        logic [NIB_W-1:0] preset_low;
        logic [NIB_W-1:0] preset_high;
    } tmr_ctl_type;

endpackage

// ===== verilog/data_nibble_ram.sv
// 128 x 4 data ram, separate write and read address, registered read data
module data_nibble_ram
    import insn_move_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // write side
    input  wire ram_wr_type        wr_port,
    // read side
    input  wire logic [RAM_AW-1:0] rd_addr,
    output logic      [NIB_W-1:0]  rd_data_q
);

    logic [NIB_W-1:0] mem [0:RAM_DEPTH-1];

    always_ff @(posedge core_clk) begin
        if (wr_port.we) begin
            mem[wr_port.addr] <= wr_port.data;
        end
    end

    // read-first: a write to the same address shows one cycle later
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data_q <= NIB_RST;
        end else begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule

// ===== verilog/timer_load_port.sv
// load strobe, load value and preset halves handed to one countdown timer
module timer_load_port
    import insn_move_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // strobes from the executor
    input  wire logic             imm_stb,
    input  wire logic [7:0]       imm_value,
    input  wire logic             low_stb,
    input  wire logic             high_stb,
    input  wire logic [NIB_W-1:0] nibble,
    // to the timer
    output tmr_ctl_type           ctl_q
);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_q.load  <= 1'b0;
            ctl_q.value <= TMR_RST;
        end else begin
            ctl_q.load <= imm_stb;
            if (imm_stb) begin
                ctl_q.value <= imm_value;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctl_q.preset_low  <= NIB_RST;
            ctl_q.preset_high <= NIB_RST;
        end else begin
            if (low_stb) begin
                ctl_q.preset_low <= nibble;
            end
            if (high_stb) begin
                ctl_q.preset_high <= nibble;
            end
        end
    end

endmodule

// ===== verilog/insn_move_exec.sv
// executor for the timer-load, ram-move, page-load and carry-copy instructions
//
// Functional notes
// - immediate load starts first timer with I7..I0
// - immediate load starts second timer, one cycle
// - ram nibble into first timer preset low
// - ram nibble into first timer preset high
// - ram nibble into second timer preset low
// - ram nibble into second timer preset high
// - direct move ram R into working register W
// - indirect read: page*10H plus nibble, two cycles
// - indirect write of working register, two cycles
// - page register loaded from ram nibble
// - carry to bit0 of acc and ram, zero flag
//
// Our own choices: the address-and-strobe port and the register offsets.
module insn_move_exec
    import insn_move_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // instruction fetch
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    output logic                   instr_ready,
    output logic                   instr_done,
    // ram writes from the rest of the core
    input  wire ram_wr_type        ram_ext_wr,
    // flags and accumulator
    input  wire logic              carry_flag,
    output logic      [NIB_W-1:0]  accumulator,
    output logic                   zero_flag,
    output logic      [NIB_W-1:0]  ram_page_select,
    // countdown timers
    output tmr_ctl_type            first_countdown_timer,
    output tmr_ctl_type            second_countdown_timer
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic op_type decode_op(input logic [15:0] w);
        op_type op;
        op = OP_NONE;
        if (w[15:11] == OPC_MOV_WR) begin
            op = OP_MOV_WR;
        end else if (w[15:11] == OPC_LD_IND) begin
            op = OP_LD_IND;
        end else if (w[15:11] == OPC_ST_IND) begin
            op = OP_ST_IND;
        end else if (w[15:8] == OPC_TM0_IMM) begin
            op = OP_TM0_IMM;
        end else if (w[15:8] == OPC_TM1_IMM) begin
            op = OP_TM1_IMM;
        end else if (w[15:8] == OPC_PAGE) begin
            op = OP_PAGE;
        end else if (w[15:7] == OPC_FIRST_TIMER_PRESET_LOW) begin
            op = OP_FIRST_TIMER_PRESET_LOW;
        end else if (w[15:7] == OPC_FIRST_TIMER_PRESET_HIGH) begin
            op = OP_FIRST_TIMER_PRESET_HIGH;
        end else if (w[15:7] == OPC_SECOND_TIMER_PRESET_LOW) begin
            op = OP_SECOND_TIMER_PRESET_LOW;
        end else if (w[15:7] == OPC_SECOND_TIMER_PRESET_HIGH) begin
            op = OP_SECOND_TIMER_PRESET_HIGH;
        end else if (w[15:7] == OPC_CF_COPY) begin
            op = OP_CF_COPY;
        end
        return op;
    endfunction

    // only pages 0..7 reachable, the page msb never reaches the address
    function automatic logic [RAM_AW-1:0] page_addr(
        input logic [NIB_W-1:0] page,
        input logic [NIB_W-1:0] ptr
    );
        return {page[PAGE_USED-1:0], ptr};
    endfunction

    function automatic logic [RAM_AW-1:0] wr_addr(input logic [15:0] w);
        return {3'b000, w[W_MSB:W_LSB]};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_type          state_q;
    state_type          state_d;
    op_type             op_q;
    logic [15:0]        instr_q;
    logic [NIB_W-1:0]   hold_q;
    logic [NIB_W-1:0]   ptr_q;
    logic               ready_q;
    logic               done_q;
    logic [NIB_W-1:0]   acc_q;
    logic               zf_q;
    logic [NIB_W-1:0]   page_q;
    logic               take;
    logic [RAM_AW-1:0]  rd_addr;
    logic [NIB_W-1:0]   rd_data_q;
    ram_wr_type         wr_int;
    ram_wr_type         ram_port;
    logic [TIMERS-1:0]  imm_stb;
    logic [TIMERS-1:0]  low_stb;
    logic [TIMERS-1:0]  high_stb;
    tmr_ctl_type [TIMERS-1:0] tmr_ctl;

    assign take = instr_valid && ready_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (take) begin
                    state_d = S_STEP1;
                end
            end
            S_STEP1: begin
                // indirect moves take a second machine cycle
                if (op_q == OP_LD_IND || op_q == OP_ST_IND) begin
                    state_d = S_STEP2;
                end else begin
                    state_d = S_IDLE;
                end
            end
            S_STEP2: begin
                state_d = S_STEP3;
            end
            S_STEP3: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            ready_q <= 1'b1;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d == S_IDLE);
            done_q  <= (state_q != S_IDLE) && (state_d == S_IDLE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            op_q    <= OP_NONE;
            instr_q <= 16'h0000;
        end else if (take) begin
            op_q    <= decode_op(instr_word);
            instr_q <= instr_word;
        end
    end

    // ------------------------------------------------------------
    // ram access
    // ------------------------------------------------------------
    always_comb begin
        rd_addr = instr_q[R_MSB:0];
        if (state_q == S_IDLE) begin
            rd_addr = instr_word[R_MSB:0];
        end else if (state_q == S_STEP1 && op_q == OP_LD_IND) begin
            rd_addr = page_addr(page_q, rd_data_q);
        end else if (state_q == S_STEP1 && op_q == OP_ST_IND) begin
            rd_addr = wr_addr(instr_q);
        end
    end

    always_comb begin
        wr_int = '0;
        if (state_q == S_STEP1 && op_q == OP_MOV_WR) begin
            wr_int.we   = 1'b1;
            wr_int.addr = wr_addr(instr_q);
            wr_int.data = rd_data_q;
        end else if (state_q == S_STEP1 && op_q == OP_CF_COPY) begin
            wr_int.we   = 1'b1;
            wr_int.addr = instr_q[R_MSB:0];
            wr_int.data = {3'b000, carry_flag};
        end else if (state_q == S_STEP3 && op_q == OP_LD_IND) begin
            wr_int.we   = 1'b1;
            wr_int.addr = wr_addr(instr_q);
            wr_int.data = hold_q;
        end else if (state_q == S_STEP3 && op_q == OP_ST_IND) begin
            wr_int.we   = 1'b1;
            wr_int.addr = page_addr(page_q, ptr_q);
            wr_int.data = hold_q;
        end
    end

    // outside writes only land while idle; the executor never writes then
    always_comb begin
        ram_port = wr_int;
        if (state_q == S_IDLE) begin
            ram_port = ram_ext_wr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr_q  <= NIB_RST;
            hold_q <= NIB_RST;
        end else begin
            if (state_q == S_STEP1) begin
                ptr_q <= rd_data_q;
            end
            if (state_q == S_STEP2) begin
                hold_q <= rd_data_q;
            end
        end
    end

    data_nibble_ram u_ram (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .wr_port   (ram_port),
        .rd_addr   (rd_addr),
        .rd_data_q (rd_data_q)
    );

    // ------------------------------------------------------------
    // page register, accumulator and zero flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            page_q <= NIB_RST;
        end else if (state_q == S_STEP1 && op_q == OP_PAGE) begin
            page_q <= rd_data_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_q <= NIB_RST;
            zf_q  <= 1'b0;
        end else if (state_q == S_STEP1 && op_q == OP_CF_COPY) begin
            acc_q <= {3'b000, carry_flag};
            zf_q  <= ~carry_flag;
        end
    end

    // ------------------------------------------------------------
    // timer strobes
    // ------------------------------------------------------------
    always_comb begin
        imm_stb  = '0;
        low_stb  = '0;
        high_stb = '0;
        if (state_q == S_STEP1) begin
            imm_stb[0]  = (op_q == OP_TM0_IMM);
            imm_stb[1]  = (op_q == OP_TM1_IMM);
            low_stb[0]  = (op_q == OP_FIRST_TIMER_PRESET_LOW);
            high_stb[0] = (op_q == OP_FIRST_TIMER_PRESET_HIGH);
            low_stb[1]  = (op_q == OP_SECOND_TIMER_PRESET_LOW);
            high_stb[1] = (op_q == OP_SECOND_TIMER_PRESET_HIGH);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < TIMERS; gi++) begin : g_tmr
            timer_load_port u_port (
                .core_clk  (core_clk),
                .sys_rst   (sys_rst),
                .imm_stb   (imm_stb[gi]),
                .imm_value (instr_q[IMM_MSB:0]),
                .low_stb   (low_stb[gi]),
                .high_stb  (high_stb[gi]),
                .nibble    (rd_data_q),
                .ctl_q     (tmr_ctl[gi])
            );
        end
    endgenerate

    assign first_countdown_timer  = tmr_ctl[0];
    assign second_countdown_timer = tmr_ctl[1];
    assign instr_ready            = ready_q;
    assign instr_done             = done_q;
    assign accumulator            = acc_q;
    assign zero_flag              = zf_q;
    assign ram_page_select        = page_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_tm0_imm_load: assert property (
        take && decode_op(instr_word) == OP_TM0_IMM |-> ##2
        first_countdown_timer.load &&
        first_countdown_timer.value == $past(instr_word[7:0], 2))
        else $error("first timer immediate load wrong");

    a_tm1_imm_load: assert property (
        take && decode_op(instr_word) == OP_TM1_IMM |-> ##2
        second_countdown_timer.load && instr_ready &&
        second_countdown_timer.value == $past(instr_word[7:0], 2))
        else $error("second timer immediate load wrong");

    a_tm0_low_write: assert property (
        state_q == S_STEP1 && op_q == OP_FIRST_TIMER_PRESET_LOW |=>
        first_countdown_timer.preset_low == $past(rd_data_q))
        else $error("first timer preset low wrong");

    a_tm0_high_write: assert property (
        state_q == S_STEP1 && op_q == OP_FIRST_TIMER_PRESET_HIGH |=>
        first_countdown_timer.preset_high == $past(rd_data_q) &&
        $stable(first_countdown_timer.preset_low))
        else $error("first timer preset high wrong");

    a_tm1_preset_write: assert property (
        state_q == S_STEP1 && (op_q == OP_SECOND_TIMER_PRESET_LOW || op_q == OP_SECOND_TIMER_PRESET_HIGH) |=>
        (($past(op_q) == OP_SECOND_TIMER_PRESET_LOW) ?
            second_countdown_timer.preset_low == $past(rd_data_q) :
            second_countdown_timer.preset_high == $past(rd_data_q)))
        else $error("second timer preset wrong");

    a_direct_wr_move: assert property (
        take && decode_op(instr_word) == OP_MOV_WR |=>
        ram_port.we && ram_port.data == rd_data_q &&
        ram_port.addr == {3'b000, $past(instr_word[10:7])})
        else $error("direct move into working register wrong");

    a_ind_read_addr: assert property (
        state_q == S_STEP1 && op_q == OP_LD_IND |->
        rd_addr == {page_q[2:0], rd_data_q} ##2
        (ram_port.we && ram_port.data == $past(rd_data_q) &&
         ram_port.addr == {3'b000, instr_q[10:7]}))
        else $error("indirect read address or data wrong");

    a_ind_two_cycles: assert property (
        take && (decode_op(instr_word) == OP_LD_IND ||
                 decode_op(instr_word) == OP_ST_IND) |=>
        !instr_ready [*3] ##1 instr_ready)
        else $error("indirect move not two machine cycles");

    a_ind_write_addr: assert property (
        state_q == S_STEP1 && op_q == OP_ST_IND |-> ##2
        ram_port.we && ram_port.addr == {page_q[2:0], $past(rd_data_q, 2)})
        else $error("indirect write address wrong");

    a_page_load: assert property (
        take && decode_op(instr_word) == OP_PAGE |-> ##2
        ram_page_select == $past(rd_data_q) && instr_done)
        else $error("page register load wrong");

    a_carry_copy: assert property (
        state_q == S_STEP1 && op_q == OP_CF_COPY |->
        ram_port.we && ram_port.data == {3'b000, carry_flag} ##1
        accumulator == {3'b000, $past(carry_flag)} &&
        zero_flag == !$past(carry_flag))
        else $error("carry copy wrong");

    c_back_to_back: cover property (take ##2 take);
    c_ind_read: cover property (take && decode_op(instr_word) == OP_LD_IND);
    c_ind_write: cover property (take && decode_op(instr_word) == OP_ST_IND);
    c_carry_one: cover property (state_q == S_STEP1 && op_q == OP_CF_COPY && carry_flag);

endmodule

// ===== bench/fetch_model.sv
// instruction fetch and program memory model feeding the executor
module fetch_model
    import insn_move_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // pacing: one idle cycle after every take
    input  wire logic        slow,
    // instruction port
    input  wire logic        instr_ready,
    output logic             instr_valid = 1'b0,
    output logic [15:0]      instr_word  = 16'h0f0f
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] prog_q[$];

    task automatic push(input logic [15:0] w);
        prog_q.push_back(w);
    endtask

    // ------------------------------------------------------------
    // offer words in order, hold each until taken
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (sys_rst) begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end else if (!instr_valid || instr_ready) begin
            if (prog_q.size() != 0 && !(slow && instr_valid)) begin
                instr_valid <= 1'b1;
                instr_word  <= prog_q.pop_front();
            end else begin
                // released word toggles so a stale value is never mistaken for data
                instr_valid <= 1'b0;
                instr_word  <= ~instr_word;
            end
        end
    end
endmodule

// ===== bench/insn_move_exec_bench.sv
// self-checking bench for the data-move and timer-load executor
module insn_move_exec_bench
    import insn_move_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk   = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        slow       = 1'b0;
    logic        carry_flag = 1'b0;
    ram_wr_type  ram_ext_wr = '0;
    logic        instr_valid;
    logic [15:0] instr_word;
    logic        instr_ready;
    logic        instr_done;
    logic [3:0]  accumulator;
    logic        zero_flag;
    logic [3:0]  ram_page_select;
    tmr_ctl_type first_countdown_timer;
    tmr_ctl_type second_countdown_timer;
    int          errors     = 0;
    int          num_checks = 0;

    always #5 core_clk = ~core_clk;

    fetch_model i_fetch (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .slow        (slow),
        .instr_ready (instr_ready),
        .instr_valid (instr_valid),
        .instr_word  (instr_word)
    );

    insn_move_exec i_dut (
        .core_clk               (core_clk),
        .sys_rst                (sys_rst),
        .instr_valid            (instr_valid),
        .instr_word             (instr_word),
        .instr_ready            (instr_ready),
        .instr_done             (instr_done),
        .ram_ext_wr             (ram_ext_wr),
        .carry_flag             (carry_flag),
        .accumulator            (accumulator),
        .zero_flag              (zero_flag),
        .ram_page_select        (ram_page_select),
        .first_countdown_timer  (first_countdown_timer),
        .second_countdown_timer (second_countdown_timer)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // preload goes only while idle, writes during execution are dropped
    task automatic poke(input logic [6:0] a, input logic [3:0] d);
        @(posedge core_clk);
        ram_ext_wr <= '{we: 1'b1, addr: a, data: d};
        @(posedge core_clk);
        ram_ext_wr.we <= 1'b0;
        // step off the edge so a following push never races the fetch model
        #1;
    endtask

    // issue one word, count edges from take to done
    task automatic run(input logic [15:0] w, input int exp_n);
        int n;
        i_fetch.push(w);
        for (n = 0; n < 20 && !(instr_valid === 1'b1 && instr_ready === 1'b1); n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 20) begin
            chk(n[7:0], exp_n[7:0]);
            results();
        end
        // n counts cycles from the take cycle to the one showing done
        for (n = 1; n < 20; n++) begin
            @(posedge core_clk);
            #1;
            if (instr_done === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            chk(n[7:0], exp_n[7:0]);
            results();
        end
        chk(n[7:0], exp_n[7:0]);
    endtask

    // a ram nibble becomes visible through the first timer's low preset
    task automatic peek(input logic [6:0] a, input logic [3:0] e);
        run({OPC_FIRST_TIMER_PRESET_LOW, a}, 2);
        chk(first_countdown_timer.preset_low, e);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk(instr_ready, 1'b1);
        chk(instr_done, 1'b0);
        chk(accumulator, NIB_RST);
        chk(zero_flag, 1'b0);
        chk(ram_page_select, NIB_RST);
        chk(first_countdown_timer.load, 1'b0);
        chk(second_countdown_timer.value, TMR_RST);
        $display("test reset done");
    endtask

    task automatic t_timer_imm();
        run({OPC_TM0_IMM, 8'ha5}, 2);
        chk(first_countdown_timer.load, 1'b1);
        chk(first_countdown_timer.value, 8'ha5);
        chk(second_countdown_timer.load, 1'b0);
        run({OPC_TM1_IMM, 8'h3c}, 2);
        chk(second_countdown_timer.load, 1'b1);
        chk(second_countdown_timer.value, 8'h3c);
        chk(first_countdown_timer.load, 1'b0);
        @(posedge core_clk);
        #1;
        chk(second_countdown_timer.load, 1'b0);
        $display("test timer_imm done");
    endtask

    task automatic t_presets();
        poke(7'h41, 4'h1);
        poke(7'h42, 4'h2);
        poke(7'h43, 4'h3);
        poke(7'h7f, 4'h4);
        run({OPC_FIRST_TIMER_PRESET_LOW, 7'h41}, 2);
        run({OPC_FIRST_TIMER_PRESET_HIGH, 7'h42}, 2);
        run({OPC_SECOND_TIMER_PRESET_LOW, 7'h43}, 2);
        run({OPC_SECOND_TIMER_PRESET_HIGH, 7'h7f}, 2);
        chk(first_countdown_timer.preset_low, 4'h1);
        chk(first_countdown_timer.preset_high, 4'h2);
        chk(second_countdown_timer.preset_low, 4'h3);
        chk(second_countdown_timer.preset_high, 4'h4);
        chk(second_countdown_timer.load, 1'b0);
        $display("test presets done");
    endtask

    task automatic t_direct();
        poke(7'h55, 4'h6);
        poke(7'h7e, 4'hc);
        run({OPC_MOV_WR, 4'h9, 7'h55}, 2);
        run({OPC_MOV_WR, 4'hf, 7'h7e}, 2);
        peek(7'h09, 4'h6);
        peek(7'h0f, 4'hc);
        $display("test direct done");
    endtask

    task automatic t_indirect();
        poke(7'h30, 4'hb);
        poke(7'h50, 4'h7);
        poke(7'h37, 4'he);
        poke(7'h07, 4'h1);
        poke(7'h06, 4'hd);
        // bit 7 of the page opcode is a don't care, so drive it high
        run({OPC_PAGE, 1'b1, 7'h30}, 2);
        chk(ram_page_select, 4'hb);
        run({OPC_LD_IND, 4'h5, 7'h50}, 4);
        peek(7'h05, 4'he);
        run({OPC_ST_IND, 4'h6, 7'h50}, 4);
        peek(7'h37, 4'hd);
        peek(7'h07, 4'h1);
        $display("test indirect done");
    endtask

    task automatic t_carry();
        slow <= 1'b1;
        poke(7'h22, 4'hf);
        carry_flag <= 1'b1;
        run({OPC_CF_COPY, 7'h22}, 2);
        chk(accumulator, 4'h1);
        chk(zero_flag, 1'b0);
        peek(7'h22, 4'h1);
        poke(7'h22, 4'hf);
        carry_flag <= 1'b0;
        run({OPC_CF_COPY, 7'h22}, 2);
        chk(accumulator, 4'h0);
        chk(zero_flag, 1'b1);
        peek(7'h22, 4'h0);
        slow <= 1'b0;
        $display("test carry done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_timer_imm();
        t_presets();
        t_direct();
        t_indirect();
        t_carry();
        results();
    end
endmodule
